/* File: logic/wmc_core.sv */
// wmc_core: modulation engine; one output sample per clock.
// assumes a same-clock register master and a same-clock sample source.
//
// The register addresses and the plain strobed port were decided locally.
`default_nettype none
module wmc_core
    import wmc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // modulation sources
    input wire logic key_pin,
    input wire logic signed [15:0] ext_sample,
    input wire logic signed [15:0] arb_sample,
    output logic [11:0] arb_index,
    // output stage
    output wmc_wave_t wave_out,
    output wmc_aux_t aux_out
);
    wmc_ctrl_t ctrl, next_ctrl;
    logic [31:0] carrier_inc, next_carrier_inc;
    logic [31:0] freq_dev, next_freq_dev;
    logic [31:0] alternate_tone, next_alternate_tone;
    logic [31:0] phase_dev, next_phase_dev;
    logic [15:0] ampl, next_ampl;
    logic [DEPTH_W-1:0] depth, next_depth;
    logic [31:0] internal_mod_rate, next_internal_mod_rate;
    logic refused, next_refused;
    logic [31:0] next_rdata;
    wmc_state_t state, next_state;
    logic conflict, keyed;

    function automatic logic bad_combo(input wmc_ctrl_t c);
        logic bad;
        bad = 1'b0;
        unique case (c.mtype)
            MT_FM, MT_FSK: bad = (c.wave == CW_NOISE) || (c.wave == CW_PULSE)
                || (c.wave == CW_DC);
            MT_PM, MT_PSK: bad = (c.wave == CW_NOISE) || (c.wave == CW_DC);
            MT_AM, MT_SCAM: bad = (c.wave == CW_DC);
            default: bad = 1'b1;
        endcase
        return bad;
    endfunction

    assign conflict = bad_combo(ctrl);
    assign keyed = (ctrl.mtype == MT_FSK) || (ctrl.mtype == MT_PSK);

    // register file
    always_comb begin
        wmc_ctrl_t req;
        logic req_keyed;
        req = wmc_ctrl_t'(wdata[CTRL_W-1:0]);
        req_keyed = (req.mtype == MT_FSK) || (req.mtype == MT_PSK);
        next_ctrl = ctrl;
        next_carrier_inc = carrier_inc;
        next_freq_dev = freq_dev;
        next_alternate_tone = alternate_tone;
        next_phase_dev = phase_dev;
        next_ampl = ampl;
        next_depth = depth;
        next_internal_mod_rate = internal_mod_rate;
        next_refused = refused;
        next_rdata = WORD_RST;
        if (wr) begin
            unique case (addr)
                REG_CTRL: begin
                    next_ctrl = req;
                    // keep an older legal select rather than drop to marker
                    if (req_keyed && req.aux == AUX_WAVE) begin
                        next_ctrl.aux = (ctrl.aux == AUX_WAVE) ? AUX_MARKER : ctrl.aux;
                        next_refused = 1'b1;
                    end else begin
                        next_refused = 1'b0;
                    end
                end
                REG_CARRIER_INC: begin
                    next_carrier_inc = wdata;
                end
                REG_FREQ_DEV: begin
                    next_freq_dev = wdata;
                end
                REG_ALT_TONE: begin
                    next_alternate_tone = wdata;
                end
                REG_PHASE_DEV: begin
                    next_phase_dev = wdata;
                end
                REG_LEVEL: begin
                    next_ampl = wdata[15:0];
                    next_depth = wdata[LEVEL_DEPTH_LSB +: DEPTH_W];
                end
                REG_MOD_RATE: begin
                    next_internal_mod_rate = wdata;
                end
                default: ;
            endcase
        end
        if (rd) begin
            unique case (addr)
                REG_CTRL: next_rdata = {18'h00000, ctrl};
                REG_STATUS: next_rdata = {24'h000000, refused, conflict, keyed, 1'b0, state};
                REG_CARRIER_INC: next_rdata = carrier_inc;
                REG_FREQ_DEV: next_rdata = freq_dev;
                REG_ALT_TONE: next_rdata = alternate_tone;
                REG_PHASE_DEV: next_rdata = phase_dev;
                REG_LEVEL: next_rdata = {9'h000, depth, ampl};
                REG_MOD_RATE: next_rdata = internal_mod_rate;
                default: next_rdata = WORD_RST;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl <= wmc_ctrl_t'(CTRL_RST);
            carrier_inc <= WORD_RST;
            freq_dev <= WORD_RST;
            alternate_tone <= WORD_RST;
            phase_dev <= WORD_RST;
            ampl <= AMPL_RST;
            depth <= DEPTH_RST;
            internal_mod_rate <= WORD_RST;
            refused <= 1'b0;
            rdata <= WORD_RST;
        end else begin
            ctrl <= next_ctrl;
            carrier_inc <= next_carrier_inc;
            freq_dev <= next_freq_dev;
            alternate_tone <= next_alternate_tone;
            phase_dev <= next_phase_dev;
            ampl <= next_ampl;
            depth <= next_depth;
            internal_mod_rate <= next_internal_mod_rate;
            refused <= next_refused;
            rdata <= next_rdata;
        end
    end

    // run control
    always_comb begin
        logic stop_req, start_req;
        stop_req = wr && (addr == REG_CMD) && wdata[CMD_STOP];
        start_req = wr && (addr == REG_CMD) && wdata[CMD_START];
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (ctrl.en) next_state = conflict ? ST_HOLD : ST_RUN;
            end
            ST_HOLD: begin
                if (!ctrl.en) next_state = ST_IDLE;
                else if (!conflict) next_state = ST_RUN;
            end
            ST_RUN: begin
                if (!ctrl.en) next_state = ST_IDLE;
                else if (conflict) next_state = ST_HOLD;
                else if (stop_req && !start_req) next_state = ST_PAUSE;
            end
            ST_PAUSE: begin
                if (!ctrl.en) next_state = ST_IDLE;
                else if (start_req) next_state = conflict ? ST_HOLD : ST_RUN;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // keying pin: three stages, change once stages two and three agree
    logic [2:0] key_sync, next_key_sync;
    logic key_lvl, next_key_lvl;
    always_comb begin
        next_key_sync = {key_sync[1:0], key_pin};
        next_key_lvl = (key_sync[1] == key_sync[2]) ? key_sync[2] : key_lvl;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            key_sync <= 3'h0;
            key_lvl <= 1'b0;
        end else begin
            key_sync <= next_key_sync;
            key_lvl <= next_key_lvl;
        end
    end

    // modulation source
    logic [31:0] mod_ph, next_mod_ph;
    logic [15:0] lfsr, next_lfsr;
    logic signed [16:0] mod_val, next_mod_val;
    logic key_on, next_key_on;
    always_comb begin
        logic [15:0] h, tri_mag;
        logic [31:0] par;
        logic signed [16:0] s;
        h = mod_ph[30:15];
        // widen first: a 32-bit context would fill the inverted upper half with ones
        par = {16'h0000, h} * {16'h0000, ~h};
        tri_mag = mod_ph[30] ? ~mod_ph[29:14] : mod_ph[29:14];
        s = FS_POS;
        next_mod_ph = mod_ph + internal_mod_rate;
        next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        unique case (ctrl.shape)
            SH_SINE: s = mod_ph[31] ? -$signed({1'b0, par[30:15]})
                : $signed({1'b0, par[30:15]});
            SH_SQUARE: begin
                s = mod_ph[31] ? FS_NEG : FS_POS;
            end
            SH_TRI: s = mod_ph[31] ? -$signed({2'b00, tri_mag[15:1]})
                : $signed({2'b00, tri_mag[15:1]});
            SH_UP: begin
                s = {mod_ph[31], mod_ph[31:16]};
            end
            SH_DOWN: begin
                s = -$signed({mod_ph[31], mod_ph[31:16]});
            end
            SH_NOISE: begin
                s = {lfsr[15], lfsr};
            end
            SH_ARB: begin
                s = {arb_sample[15], arb_sample};
            end
            default: s = {17{1'b0}};
        endcase
        // external full scale maps to exactly plus or minus 2^15
        if (ctrl.ext) begin
            s = (ext_sample == $signed(EXT_MAX)) ? FS_POS
                : {ext_sample[15], ext_sample};
        end
        next_mod_val = s;
        // keyed modes ignore the shape: the internal square, or the keying pin (with neg) when ext is set
        next_key_on = ctrl.ext ? (key_lvl ^ ctrl.neg) : ~mod_ph[31];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mod_ph <= WORD_RST;
            lfsr <= LFSR_SEED;
            mod_val <= {17{1'b0}};
            key_on <= 1'b0;
        end else begin
            mod_ph <= next_mod_ph;
            lfsr <= next_lfsr;
            mod_val <= next_mod_val;
            key_on <= next_key_on;
        end
    end

    // carrier and modulation arithmetic
    logic [31:0] car_ph, next_car_ph;
    wmc_wave_t next_wave;
    always_comb begin
        logic run;
        logic [31:0] inc, ph_off;
        logic signed [49:0] fm_p, pm_p;
        logic signed [24:0] dep_p, dep_q;
        logic signed [17:0] am_g;
        logic signed [34:0] am_p;
        logic signed [33:0] sc_p;
        run = (state == ST_RUN);
        fm_p = $signed({1'b0, freq_dev}) * mod_val;
        pm_p = $signed({1'b0, phase_dev}) * mod_val;
        dep_p = mod_val * $signed({1'b0, depth});
        dep_q = dep_p / DEPTH_FULL;
        am_g = GAIN_UNITY + dep_q[17:0];
        if (!run) am_g = GAIN_UNITY;
        am_p = $signed({1'b0, ampl}) * am_g;
        // part-select is unsigned; recast so negative values invert the output
        sc_p = $signed({1'b0, ampl}) * $signed(dep_q[16:0]);
        inc = carrier_inc;
        ph_off = WORD_RST;
        next_wave.amp = $signed({1'b0, ampl});
        if (run) begin
            unique case (ctrl.mtype)
                MT_FM: begin
                    inc = carrier_inc + fm_p[46:15];
                end
                MT_FSK: begin
                    inc = key_on ? alternate_tone : carrier_inc;
                end
                MT_PM: begin
                    ph_off = pm_p[46:15];
                end
                MT_PSK: begin
                    ph_off = key_on ? phase_dev : WORD_RST;
                end
                MT_SCAM: begin
                    next_wave.amp = sc_p[31:15];
                end
                default: ;
            endcase
        end
        // AM keeps half level even while paused
        if (ctrl.en && ctrl.mtype == MT_AM && state != ST_HOLD) begin
            next_wave.amp = am_p[32:16];
        end
        // accumulator never reloads, so any frequency change is phase-continuous
        next_car_ph = car_ph + inc;
        next_wave.phase = car_ph + ph_off;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            car_ph <= WORD_RST;
            wave_out <= '0;
        end else begin
            car_ph <= next_car_ph;
            wave_out <= next_wave;
        end
    end

    // auxiliary output
    wmc_aux_t next_aux;
    always_comb begin
        next_aux.wave = mod_val;
        next_aux.wave_en = 1'b0;
        next_aux.level = 1'b0;
        unique case (ctrl.aux)
            AUX_MARKER: begin
                next_aux.level = ~next_wave.phase[31];
            end
            AUX_LOCKED: begin
                next_aux.level = (ctrl.shape != SH_NOISE) && ~mod_ph[31];
            end
            AUX_WAVE: begin
                next_aux.wave_en = !keyed;
            end
            default: ;
        endcase
        if (!next_aux.wave_en) next_aux.wave = {17{1'b0}};
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            aux_out <= '0;
            arb_index <= 12'h000;
        end else begin
            aux_out <= next_aux;
            arb_index <= next_mod_ph[31:20];
        end
    end
endmodule
`default_nettype wire

/* File: logic/wmc_pkg.sv */
// wmc_pkg: constants and types of the waveform modulation core.
// assumes one 125 MHz clock; the core computes one sample per clock.
`default_nettype none
package wmc_pkg;
    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_CARRIER_INC = 8'h0C;
    localparam logic [7:0] REG_FREQ_DEV = 8'h10;
    localparam logic [7:0] REG_ALT_TONE = 8'h14;
    localparam logic [7:0] REG_PHASE_DEV = 8'h18;
    localparam logic [7:0] REG_LEVEL = 8'h1C;
    localparam logic [7:0] REG_MOD_RATE = 8'h20;
    // field positions
    localparam int CTRL_W = 14;
    localparam int CMD_STOP = 0;
    localparam int CMD_START = 1;
    localparam int LEVEL_DEPTH_LSB = 16;
    localparam int DEPTH_W = 7;
    localparam int STAT_W = 8;
    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 14'h0000;
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [15:0] AMPL_RST = 16'h0000;
    localparam logic [DEPTH_W-1:0] DEPTH_RST = 7'h00;
    localparam logic [15:0] LFSR_SEED = 16'hACE1;
    // scaling
    localparam logic signed [17:0] GAIN_UNITY = 18'sh08000;
    localparam logic signed [24:0] DEPTH_FULL = 25'sh0000064;
    localparam logic signed [16:0] FS_POS = 17'sh08000;
    localparam logic signed [16:0] FS_NEG = -17'sh08000;
    localparam logic [15:0] EXT_MAX = 16'h7FFF;
    // modulation types
    localparam logic [2:0] MT_FM = 3'h0;
    localparam logic [2:0] MT_FSK = 3'h1;
    localparam logic [2:0] MT_PM = 3'h2;
    localparam logic [2:0] MT_PSK = 3'h3;
    localparam logic [2:0] MT_AM = 3'h4;
    localparam logic [2:0] MT_SCAM = 3'h5;
    // internal_mod_shape codes
    localparam logic [2:0] SH_SINE = 3'h0;
    localparam logic [2:0] SH_SQUARE = 3'h1;
    localparam logic [2:0] SH_TRI = 3'h2;
    localparam logic [2:0] SH_UP = 3'h3;
    localparam logic [2:0] SH_DOWN = 3'h4;
    localparam logic [2:0] SH_NOISE = 3'h5;
    localparam logic [2:0] SH_ARB = 3'h6;
    // carrier waveform codes
    localparam logic [2:0] CW_PULSE = 3'h4;
    localparam logic [2:0] CW_NOISE = 3'h5;
    localparam logic [2:0] CW_DC = 3'h6;
    // aux_output_select codes
    localparam logic [1:0] AUX_MARKER = 2'h0;
    localparam logic [1:0] AUX_LOCKED = 2'h1;
    localparam logic [1:0] AUX_WAVE = 2'h2;
    typedef struct packed {
        logic [2:0] wave;
        logic neg;
        logic [1:0] aux;
        logic [2:0] shape;
        logic ext;
        logic [2:0] mtype;
        logic en;
    } wmc_ctrl_t;
    typedef struct packed {
        logic [31:0] phase;
        logic signed [16:0] amp;
    } wmc_wave_t;
    typedef struct packed {
        logic level;
        logic wave_en;
        logic signed [16:0] wave;
    } wmc_aux_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_HOLD = 4'b0010,
        ST_RUN = 4'b0100,
        ST_PAUSE = 4'b1000
    } wmc_state_t;
endpackage
`default_nettype wire

/* File: verif/waveform_modulation_core_tb.sv */
// waveform_modulation_core_tb: self-checking bench for wmc_core.
// assumes wmc_core_props binds itself and wmc_src_model drives the sources.
`default_nettype none
module waveform_modulation_core_tb
    import wmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        int kind;
        logic [31:0] val;
    } wmc_note_t;
    localparam logic signed [15:0] FSP = 16'sh7FFF;
    localparam logic signed [15:0] FSN = 16'sh8000;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic key_req = 1'b0;
    logic signed [15:0] ext_req = 16'sh0000;
    logic samp = 1'b0;
    logic clr = 1'b0;
    logic [31:0] rdata;
    logic key_pin;
    logic signed [15:0] ext_sample;
    logic signed [15:0] arb_sample;
    logic [11:0] arb_index;
    wmc_wave_t wave_out;
    wmc_aux_t aux_out;
    logic [31:0] prev_ph;
    logic [31:0] hc;
    logic [31:0] seen;
    logic [31:0] rnd = 32'hE494;
    int num_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    wmc_note_t q[$];
    string nm[7] = '{"rdata", "phase", "amp", "phase step", "high count", "wave_en",
        "aux wave"};
    always #4 clk = ~clk;
    wmc_core i_dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .key_pin(key_pin), .ext_sample(ext_sample), .arb_sample(arb_sample),
        .arb_index(arb_index), .wave_out(wave_out), .aux_out(aux_out));
    wmc_src_model i_src (.clk(clk), .key_req(key_req), .ext_req(ext_req),
        .arb_index(arb_index), .key_pin(key_pin), .ext_sample(ext_sample),
        .arb_sample(arb_sample));
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // watcher: takes the oldest note whenever a sample is flagged
    always @(posedge clk) begin
        prev_ph <= wave_out.phase;
        hc <= clr ? 32'h0000_0000 : hc + {31'h0, aux_out.level};
        if (samp) begin
            case (q[0].kind)
                0: seen = rdata;
                1: seen = wave_out.phase;
                2: seen = {{15{wave_out.amp[16]}}, wave_out.amp};
                3: seen = wave_out.phase - prev_ph;
                4: seen = hc;
                6: seen = {{15{aux_out.wave[16]}}, aux_out.wave};
                default: seen = {31'h0, aux_out.wave_en};
            endcase
            n_tests++;
            if (seen !== q[0].val) begin
                num_errors++;
                $display("wrong value %s expected %h seen %h", nm[q[0].kind], q[0].val, seen);
            end
            void'(q.pop_front());
        end
    end
    // hang guard, well beyond the roughly one thousand cycles the run needs
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors = num_errors + 1;
            end_sim;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction
    function automatic logic [31:0] mk(input logic [2:0] mt, input logic ext,
        input logic [2:0] sh, input logic [1:0] ax, input logic ng, input logic [2:0] wv);
        wmc_ctrl_t c;
        c = '{wave: wv, neg: ng, aux: ax, shape: sh, ext: ext, mtype: mt, en: 1'b1};
        return {18'h0, c};
    endfunction
    task automatic note(input int k, input logic [31:0] v);
        q.push_back('{k, v});
        samp <= 1'b1;
        @(posedge clk);
        samp <= 1'b0;
    endtask
    task automatic chk_at(input int k, input logic [31:0] v);
        repeat (12) @(posedge clk);
        note(k, v);
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        note(0, v);
    endtask
    task automatic mod_case(input logic [2:0] mt, input logic [6:0] d,
        input logic signed [15:0] e, input int k, input logic [31:0] v);
        wr_reg(REG_LEVEL, {9'h0, d, 16'h4000});
        wr_reg(REG_CTRL, mk(mt, 1'b1, SH_SINE, AUX_MARKER, 1'b0, 3'h0));
        ext_req <= e;
        chk_at(k, v);
    endtask
    // every polarity and key level of an externally keyed mode
    task automatic keyed(input logic [2:0] mt, input int k, input logic [31:0] on, off);
        for (int i = 0; i < 4; i++) begin
            wr_reg(REG_CTRL, mk(mt, 1'b1, SH_SQUARE, AUX_MARKER, i[1], 3'h0));
            key_req <= i[0];
            chk_at(k, (i[0] ^ i[1]) ? on : off);
        end
    endtask
    initial begin
        logic [2:0] wv;
        logic cf;
        logic kd;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(REG_STATUS, 32'h0000_0001);
        rd_chk(8'h24, 32'h0000_0000);
        rd_chk(REG_CMD, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            rnd = xs(rnd);
            wr_reg(i == 0 ? REG_PHASE_DEV : REG_MOD_RATE, rnd);
            rd_chk(i == 0 ? REG_PHASE_DEV : REG_MOD_RATE, rnd);
        end
        $display("test registers done");
        wr_reg(REG_LEVEL, 32'h0064_4000);
        for (int m = 0; m < 6; m++) begin
            for (int w = 0; w < 4; w++) begin
                wv = (w == 0) ? 3'h0 : 3'(7 - w);
                cf = (m < 2) ? (wv != 3'h0) : ((m < 4) ? (wv >= CW_NOISE) : (wv == CW_DC));
                kd = (m == 1 || m == 3);
                wr_reg(REG_CTRL, mk(3'(m), 1'b0, SH_SINE, AUX_MARKER, 1'b0, wv));
                repeat (10) @(posedge clk);
                rd_chk(REG_STATUS, {24'h0, 1'b0, cf, kd, 1'b0, cf ? 4'h2 : 4'h4});
            end
        end
        $display("test carrier conflicts done");
        wr_reg(REG_CTRL, mk(MT_FM, 1'b0, SH_SINE, AUX_MARKER, 1'b0, 3'h0));
        wr_reg(REG_CMD, 32'h0000_0001);
        rd_chk(REG_STATUS, 32'h0000_0008);
        wr_reg(REG_CMD, 32'h0000_0003);
        rd_chk(REG_STATUS, 32'h0000_0004);
        wr_reg(REG_CTRL, mk(MT_FSK, 1'b0, SH_SQUARE, AUX_WAVE, 1'b0, 3'h0));
        rd_chk(REG_CTRL, mk(MT_FSK, 1'b0, SH_SQUARE, AUX_MARKER, 1'b0, 3'h0));
        rd_chk(REG_STATUS, 32'h0000_00A4);
        $display("test pause and refusal done");
        // carrier increment still zero, so output phase is the offset alone
        wr_reg(REG_PHASE_DEV, 32'h1000_0000);
        mod_case(MT_PM, 7'h64, FSP, 1, 32'h1000_0000);
        mod_case(MT_PM, 7'h64, FSN, 1, 32'hF000_0000);
        keyed(MT_PSK, 1, 32'h1000_0000, 32'h0000_0000);
        $display("test phase done");
        mod_case(MT_AM, 7'h64, FSP, 2, 32'h0000_4000);
        wr_reg(REG_CMD, 32'h0000_0001);
        chk_at(2, 32'h0000_2000);
        wr_reg(REG_CMD, 32'h0000_0002);
        mod_case(MT_AM, 7'h64, FSN, 2, 32'h0000_0000);
        mod_case(MT_AM, 7'h32, FSP, 2, 32'h0000_3000);
        mod_case(MT_AM, 7'h00, FSP, 2, 32'h0000_2000);
        mod_case(MT_SCAM, 7'h64, FSP, 2, 32'h0000_4000);
        mod_case(MT_SCAM, 7'h64, FSN, 2, 32'hFFFF_C000);
        $display("test amplitude done");
        wr_reg(REG_CARRIER_INC, 32'h0100_0000);
        rd_chk(REG_CARRIER_INC, 32'h0100_0000);
        wr_reg(REG_FREQ_DEV, 32'h0040_0000);
        wr_reg(REG_ALT_TONE, 32'h0300_0000);
        mod_case(MT_FM, 7'h64, FSP, 3, 32'h0140_0000);
        mod_case(MT_FM, 7'h64, FSN, 3, 32'h00C0_0000);
        keyed(MT_FSK, 3, 32'h0300_0000, 32'h0100_0000);
        $display("test frequency done");
        wr_reg(REG_MOD_RATE, 32'h0400_0000);
        for (int i = 0; i < 3; i++) begin
            wr_reg(REG_CTRL, mk(i == 2 ? MT_FSK : MT_FM, 1'b0, i == 1 ? SH_NOISE : SH_SINE,
                AUX_LOCKED, 1'b0, 3'h0));
            repeat (12) @(posedge clk);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            repeat (64) @(posedge clk);
            note(4, (i == 1) ? 32'h0000_0000 : 32'h0000_0020);
        end
        wr_reg(REG_CTRL, mk(MT_AM, 1'b0, SH_TRI, AUX_WAVE, 1'b0, 3'h0));
        chk_at(5, 32'h0000_0001);
        $display("test aux output done");
        // mid-run reset: modulation phase and rate return to zero and stay frozen
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rd_chk(REG_STATUS, 32'h0000_0001);
        wr_reg(REG_CTRL, mk(MT_AM, 1'b0, SH_SQUARE, AUX_WAVE, 1'b0, 3'h0));
        chk_at(6, 32'h0000_8000);
        wr_reg(REG_CTRL, mk(MT_AM, 1'b0, SH_ARB, AUX_WAVE, 1'b0, 3'h0));
        chk_at(6, 32'h0000_0000);
        $display("test reset and aux wave done");
        end_sim;
    end
endmodule
`default_nettype wire

/* File: verif/wmc_core_props.sv */
// wmc_core_props: port-level assertions for wmc_core.
// assumes register writes land one cycle after the strobe; shadows track them here.
`default_nettype none
module wmc_core_props
    import wmc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    // output stage
    input wire wmc_wave_t wave_out,
    input wire wmc_aux_t aux_out
);
    wmc_ctrl_t sh;
    logic [15:0] ampl;
    logic [6:0] depth;
    logic [3:0] quiet;
    logic ok;
    logic keyed;
    // shadow settings; checks wait for the pipeline to drain after any write
    always_ff @(posedge clk) begin
        if (rst) begin
            sh <= wmc_ctrl_t'(CTRL_RST);
            ampl <= AMPL_RST;
            depth <= DEPTH_RST;
            quiet <= 4'h0;
        end else begin
            quiet <= wr ? 4'h0 : ((quiet == 4'hF) ? quiet : quiet + 4'h1);
            if (wr && addr == REG_CTRL) begin
                sh <= wmc_ctrl_t'(wdata[CTRL_W-1:0]);
            end
            if (wr && addr == REG_LEVEL) begin
                ampl <= wdata[15:0];
                depth <= wdata[LEVEL_DEPTH_LSB +: DEPTH_W];
            end
        end
    end
    assign ok = quiet > 4'h8;
    assign keyed = sh.mtype == MT_FSK || sh.mtype == MT_PSK;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_no_rd;
        !rd;
    endsequence
    sequence s_settled_am;
        ok && sh.en && sh.mtype == MT_AM && sh.wave != CW_DC;
    endsequence
    AST_RDATA_IDLE: assert property (s_no_rd |=> rdata == 32'h0000_0000)
        else $error("read data not zero outside read answer");
    AST_WAVE_GATE: assert property (!aux_out.wave_en |-> aux_out.wave == '0)
        else $error("aux wave not zero while not routed");
    AST_WAVE_ROUTE: assert property (ok && sh.en && sh.aux == AUX_WAVE && !keyed |-> aux_out.wave_en)
        else $error("aux wave not routed");
    AST_KEYED_NO_WAVE: assert property (ok && keyed |-> !aux_out.wave_en)
        else $error("aux wave routed in keyed mode");
    AST_MARKER: assert property (ok && sh.aux == AUX_MARKER |->
        aux_out.level != wave_out.phase[31] || aux_out.level != $past(wave_out.phase[31]))
        else $error("marker not tied to output phase");
    AST_LOCK_NOISE: assert property (ok && sh.aux == AUX_LOCKED && sh.shape == SH_NOISE && !keyed |-> !aux_out.level)
        else $error("locked square moves with noise shape");
    AST_AM_HALF: assert property (s_settled_am ##0 depth == 7'h00 |-> wave_out.amp == {2'b00, ampl[15:1]})
        else $error("zero depth amplitude not half");
    AST_AM_PEAK: assert property (s_settled_am ##0 depth == 7'h64 |-> $signed(wave_out.amp) <= $signed({1'b0, ampl}))
        else $error("full depth envelope above carrier amplitude");
    AST_DC_HOLD: assert property (ok && sh.en && sh.mtype >= MT_AM && sh.wave == CW_DC |-> wave_out.amp == {1'b0, ampl})
        else $error("amplitude modulated on dc carrier");
endmodule
bind wmc_core wmc_core_props i_props (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .wave_out(wave_out), .aux_out(aux_out));
`default_nettype wire

/* File: verif/wmc_src_model.sv */
// wmc_src_model: keying pin, external sample and arb memory feeding the core.
// assumes the bench sets the requested levels; arb memory is a plain ramp.
`default_nettype none
module wmc_src_model (
    // bench requests
    input wire logic clk,
    input wire logic key_req,
    input wire logic signed [15:0] ext_req,
    // core side
    input wire logic [11:0] arb_index,
    output logic key_pin,
    output logic signed [15:0] ext_sample,
    output logic signed [15:0] arb_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    // key is asynchronous: lands mid-cycle so the synchroniser is exercised
    assign #3 key_pin = key_req;
    assign arb_sample = $signed({arb_index, 4'h0});
    always_ff @(posedge clk) begin
        ext_sample <= ext_req;
    end
endmodule
`default_nettype wire
